//--- design/pms_sequencer.sv
// Power mode sequencer with AHB-Lite register slave for a four-channel PDM converter
//
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "pms_map.svh"

module pms_sequencer
  import pms_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = (`PMS_INIT_WAIT_US * 1000) / `PMS_CLK_PERIOD_NS,
  parameter int unsigned WAKE_CYCLES = (`PMS_WAKE_WAIT_US * 1000) / `PMS_CLK_PERIOD_NS,
  parameter int unsigned RAMP_CYCLES = (`PMS_RAMP_WAIT_US * 1000) / `PMS_CLK_PERIOD_NS
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  input  wire logic        i_bit_clk,
  input  wire logic        i_frame_sync,
  output logic             o_mic_bitstream_clock_out,
  output logic [3:0]       o_in_ch_en,
  output logic [3:0]       o_slot_en,
  output logic             o_conv_pwr,
  output logic             o_pll_pwr,
  output logic             o_regulator_en,
  output logic             o_shutdown,
  output logic             o_recording
);

  logic [7:0]         regs_ff [`PMS_NUM_REGS];
  pms_state_e         state_ff;
  pms_state_e         nxt_state;
  logic [16:0]        timer_ff;
  logic [8:0]         frames_ff;
  pms_bus_req_s       req_ff;
  logic [31:0]        rdata_ff;
  logic [2:0]         bclk_sync_ff;
  logic [2:0]         fsync_sync_ff;
  logic               fsync_rise;
  logic               frames_seen_ff;
  logic [1:0]         mic_div_ff;
  logic               mic_clk_ff;
  logic               analog_regulator_rail_ff;
  pms_path_s          path_ff;
  logic               wr_commit;
  logic               sleep_bit;
  logic               swreset;
  logic               timer_done;
  logic [`PMS_IDX_W-1:0] addr_idx;
  logic               addr_mapped;
  logic [7:0]         status_byte;

  // Zero wait states, always OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = rdata_ff;

  assign addr_idx    = i_haddr[`PMS_IDX_W+1:2];
  assign addr_mapped = (i_haddr[31:`PMS_IDX_W+2] == '0) && (i_haddr[1:0] == 2'h0);

  // Writes before initialization ends are dropped
  assign wr_commit = req_ff.valid && req_ff.write && req_ff.mapped &&
                     (state_ff != PMS_ST_INIT) &&
                     (req_ff.idx != `PMS_IDX_DEV_STATUS);
  assign swreset   = wr_commit && (req_ff.idx == `PMS_IDX_SWRESET) &&
                     i_hwdata[`PMS_BIT_SWRESET];
  assign sleep_bit = regs_ff[`PMS_IDX_SLEEP_CTRL][`PMS_BIT_SLEEP];

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      req_ff <= '0;
    end else if (i_hready) begin
      req_ff.valid  <= i_hsel && i_htrans[1];
      req_ff.write  <= i_hwrite;
      req_ff.mapped <= addr_mapped;
      req_ff.idx    <= addr_idx;
    end
  end

  // Shutdown flag in bit 7, sequence busy in bit 6
  always_comb begin
    status_byte = 8'h00;
    status_byte[`PMS_BIT_SHUTDOWN] = (state_ff == PMS_ST_SLEEP);
    status_byte[`PMS_BIT_BUSY] = (state_ff == PMS_ST_WAKING) || (state_ff == PMS_ST_RAMP);
  end

  // Read data registered in the address phase; forward a write still in its data phase
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
      if (!addr_mapped || state_ff == PMS_ST_INIT) begin
        rdata_ff <= 32'h0000_0000;
      end else if (addr_idx == `PMS_IDX_DEV_STATUS) begin
        rdata_ff <= {24'h00_0000, status_byte};
      end else if (wr_commit && req_ff.idx == addr_idx) begin
        rdata_ff <= {24'h00_0000, i_hwdata[7:0]};
      end else begin
        rdata_ff <= {24'h00_0000, regs_ff[addr_idx]};
      end
    end
  end

  // Register array; nothing here depends on the sleep state, so all values survive it
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < `PMS_NUM_REGS; i++) begin
        regs_ff[i] <= `PMS_RST_OTHER;
      end
      regs_ff[`PMS_IDX_SLEEP_CTRL] <= `PMS_RST_SLEEP_CTRL;
      regs_ff[`PMS_IDX_IN_CH_EN]   <= `PMS_RST_IN_CH_EN;
    end else if (swreset) begin
      for (int i = 0; i < `PMS_NUM_REGS; i++) begin
        regs_ff[i] <= `PMS_RST_OTHER;
      end
      regs_ff[`PMS_IDX_SLEEP_CTRL] <= `PMS_RST_SLEEP_CTRL;
      regs_ff[`PMS_IDX_IN_CH_EN]   <= `PMS_RST_IN_CH_EN;
    end else if (wr_commit && req_ff.idx != `PMS_IDX_SWRESET) begin
      regs_ff[req_ff.idx] <= i_hwdata[7:0];
    end
  end

  // Link clocks pass two flops; frame sync edges found between second and third, bit clock taken as a level from the third
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bclk_sync_ff  <= 3'h0;
      fsync_sync_ff <= 3'h0;
    end else begin
      bclk_sync_ff  <= {bclk_sync_ff[1:0], i_bit_clk};
      fsync_sync_ff <= {fsync_sync_ff[1:0], i_frame_sync};
    end
  end

  assign fsync_rise = fsync_sync_ff[1] && !fsync_sync_ff[2];

  // Set by a frame sync edge; cleared in the sleep state in any cycle without one
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      frames_seen_ff <= 1'b0;
    end else if (fsync_rise) begin
      frames_seen_ff <= 1'b1;
    end else if (state_ff == PMS_ST_SLEEP) begin
      frames_seen_ff <= 1'b0;
    end
  end

  assign timer_done = (timer_ff == 17'h0_0000);

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PMS_ST_INIT: begin
        if (timer_done) begin
          nxt_state = PMS_ST_SLEEP;
        end
      end
      PMS_ST_SLEEP: begin
        if (!sleep_bit) begin
          nxt_state = PMS_ST_WAKING;
        end
      end
      PMS_ST_WAKING: begin
        if (sleep_bit) begin
          nxt_state = PMS_ST_RAMP;
        end else if (timer_done) begin
          nxt_state = PMS_ST_ACTIVE;
        end
      end
      PMS_ST_ACTIVE: begin
        if (sleep_bit) begin
          nxt_state = PMS_ST_RAMP;
        end
      end
      PMS_ST_RAMP: begin
        // Frame count ends the ramp if 288 frames come before the timer runs out; the timer covers slow and stopped clocks
        if (timer_done || frames_ff == 9'(`PMS_RAMP_FRAMES)) begin
          nxt_state = PMS_ST_SLEEP;
        end
      end
      default: begin
        nxt_state = PMS_ST_INIT;
      end
    endcase
    if (swreset) begin
      nxt_state = PMS_ST_INIT;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= PMS_ST_INIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // One timer, loaded on entry to each timed phase
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      timer_ff <= 17'(INIT_CYCLES - 1);
    end else if (nxt_state != state_ff) begin
      case (nxt_state)
        PMS_ST_INIT:   timer_ff <= 17'(INIT_CYCLES - 1);
        PMS_ST_WAKING: timer_ff <= 17'(WAKE_CYCLES - 1);
        PMS_ST_RAMP:   timer_ff <= 17'(RAMP_CYCLES - 1);
        default:       timer_ff <= 17'h0_0000;
      endcase
    end else if (!timer_done) begin
      timer_ff <= timer_ff - 17'h0_0001;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      frames_ff <= 9'h000;
    end else if (state_ff != PMS_ST_RAMP) begin
      frames_ff <= 9'h000;
    end else if (fsync_rise) begin
      frames_ff <= frames_ff + 9'h001;
    end
  end

  // Path enables follow registers only while active; they fall as the ramp starts
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      path_ff <= '0;
    end else if (state_ff == PMS_ST_ACTIVE && !sleep_bit) begin
      path_ff.in_ch_en <= regs_ff[`PMS_IDX_IN_CH_EN][7:4];
      path_ff.slot_en  <= regs_ff[`PMS_IDX_SLOT_EN][7:4];
      path_ff.conv_pwr <= regs_ff[`PMS_IDX_PWR_CFG][`PMS_BIT_CONV_PWR];
      path_ff.pll_pwr  <= regs_ff[`PMS_IDX_PWR_CFG][`PMS_BIT_PLL_PWR];
    end else begin
      path_ff <= '0;
    end
  end

  // Regulator choice taken only on leaving sleep
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      analog_regulator_rail_ff <= 1'b0;
    end else if (state_ff == PMS_ST_SLEEP && !sleep_bit) begin
      analog_regulator_rail_ff <= regs_ff[`PMS_IDX_SLEEP_CTRL][`PMS_BIT_ANALOG_REGULATOR_RAIL_EN];
    end else if (state_ff == PMS_ST_INIT) begin
      analog_regulator_rail_ff <= 1'b0;
    end
  end

  // Microphone clock from the reference clock, only when an output pin function is set
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mic_div_ff <= 2'h0;
      mic_clk_ff <= 1'b0;
    end else if (!path_ff.conv_pwr || regs_ff[`PMS_IDX_OUTPIN_FN] == `PMS_RST_OTHER) begin
      mic_div_ff <= 2'h0;
      mic_clk_ff <= 1'b0;
    end else if (mic_div_ff == 2'(`PMS_MIC_CLK_HALF - 1)) begin
      mic_div_ff <= 2'h0;
      mic_clk_ff <= !mic_clk_ff;
    end else begin
      mic_div_ff <= mic_div_ff + 2'h1;
    end
  end

  assign o_mic_bitstream_clock_out = mic_clk_ff;
  assign o_in_ch_en     = path_ff.in_ch_en;
  assign o_slot_en      = path_ff.slot_en;
  assign o_conv_pwr     = path_ff.conv_pwr;
  assign o_pll_pwr      = path_ff.pll_pwr;
  assign o_regulator_en = analog_regulator_rail_ff;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_shutdown  <= 1'b1;
      o_recording <= 1'b0;
    end else begin
      o_shutdown  <= (nxt_state == PMS_ST_SLEEP) || (nxt_state == PMS_ST_INIT);
      o_recording <= path_ff.conv_pwr && frames_seen_ff && bclk_sync_ff[2];
    end
  end

endmodule

`default_nettype wire

//--- design/pms_map.svh
// Register map, field positions, reset values and timing figures of the sequencer
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH

`define PMS_CLK_PERIOD_NS   100
`define PMS_INIT_WAIT_US    1000
`define PMS_WAKE_WAIT_US    1000
`define PMS_RAMP_WAIT_US    6000
`define PMS_RAMP_FRAMES     288
`define PMS_MIC_CLK_HALF    2

`define PMS_IDX_W           7
`define PMS_NUM_REGS        128
`define PMS_IDX_SWRESET     7'h01
`define PMS_IDX_SLEEP_CTRL  7'h02
`define PMS_IDX_OUTPIN_FN   7'h22
`define PMS_IDX_INPIN_FN    7'h2B
`define PMS_IDX_CH2_SRC     7'h41
`define PMS_IDX_IN_CH_EN    7'h73
`define PMS_IDX_SLOT_EN     7'h74
`define PMS_IDX_PWR_CFG     7'h75
`define PMS_IDX_DEV_STATUS  7'h77

`define PMS_BIT_SLEEP       0
`define PMS_BIT_ANALOG_REGULATOR_RAIL_EN     7
`define PMS_BIT_SWRESET     0
`define PMS_BIT_SHUTDOWN    7
`define PMS_BIT_BUSY        6
`define PMS_BIT_CONV_PWR    6
`define PMS_BIT_PLL_PWR     5

`define PMS_RST_SLEEP_CTRL  8'h01
`define PMS_RST_IN_CH_EN    8'hF0
`define PMS_RST_OTHER       8'h00

`endif

//--- design/pms_pkg.sv
// Types shared by the power mode sequencer
`default_nettype none
package pms_pkg;

  typedef enum logic [2:0] {
    PMS_ST_INIT,
    PMS_ST_SLEEP,
    PMS_ST_WAKING,
    PMS_ST_ACTIVE,
    PMS_ST_RAMP
  } pms_state_e;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       mapped;
    logic [6:0] idx;
  } pms_bus_req_s;

  typedef struct packed {
    logic [3:0] in_ch_en;
    logic [3:0] slot_en;
    logic       conv_pwr;
    logic       pll_pwr;
  } pms_path_s;

endpackage

`default_nettype wire

//--- sim/pms_link_host.sv
// Far-side host model making the audio frame and bit clocks
`timescale 1ns/1ns
`default_nettype none
module pms_link_host (
  input  wire logic i_run,
  output logic      o_bit_clk,
  output logic      o_frame_sync
);
  // Whole frames only, so a stop never cuts a frame short
  initial begin
    o_bit_clk = 1'b0;
    o_frame_sync = 1'b0;
    forever begin
      wait (i_run);
      // Keep link edges off the reference clock's rising edge
      if ($time % 100 == 50) #25;
      for (int b = 0; b < 8; b++) begin
        o_frame_sync = (b == 0);
        #400 o_bit_clk = 1'b1;
        #400 o_bit_clk = 1'b0;
      end
      o_frame_sync = 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- sim/pms_sequencer_checker.sv
// Assertions on the sequencer's bus and power outputs
`timescale 1ns/1ns
`default_nettype none
module pms_sequencer_checker #(
  parameter int unsigned RAMP_CYCLES = 60000
) (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_mic_bitstream_clock_out,
  input wire logic [3:0]  o_slot_en,
  input wire logic        o_conv_pwr,
  input wire logic        o_pll_pwr,
  input wire logic        o_shutdown,
  input wire logic        o_recording
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  int unsigned ramp_ff;
  // Counter, since the ramp can outlast any delay range
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) ramp_ff <= 0;
    else if (o_shutdown) ramp_ff <= 0;
    else if (ramp_ff != 0 || $fell(o_conv_pwr)) ramp_ff <= ramp_ff + 1;
  end
  sequence s_clk_hi_lo;
    o_mic_bitstream_clock_out ##1 !o_mic_bitstream_clock_out;
  endsequence
  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus not ready or not okay");
  a_rdata_byte: assert property (o_hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_init_sleeps: assert property ($fell(i_rst) |-> o_shutdown[*8])
    else $error("left shutdown during init");
  a_asleep_quiet: assert property (o_shutdown && $past(o_shutdown) |->
    !o_conv_pwr && !o_pll_pwr && o_slot_en == 4'h0) else $error("path on in sleep");
  a_wake_waits: assert property ($fell(o_shutdown) |->
    (!o_conv_pwr && !o_recording)[*8]) else $error("powered during wake");
  a_ramp_min: assert property ($fell(o_conv_pwr) && !o_shutdown |=> !o_shutdown[*8])
    else $error("ramp too short");
  a_ramp_bound: assert property (ramp_ff <= RAMP_CYCLES + 4)
    else $error("ramp too long");
  a_mic_clk_rate: assert property ($rose(o_mic_bitstream_clock_out) ##1 o_conv_pwr
    |-> s_clk_hi_lo) else $error("mic clock rate wrong");
endmodule
bind pms_sequencer pms_sequencer_checker #(.RAMP_CYCLES(RAMP_CYCLES)) i_chk (.*);
`default_nettype wire

//--- sim/pms_sequencer_tb.sv
// Self-checking bench for the power mode sequencer
`timescale 1ns/1ns
`default_nettype none
module pms_sequencer_tb;
  localparam int IC = 20, WC = 20, RC = 50;
  logic        clk, rst, hsel, hwr, run;
  logic [1:0]  htr;
  logic [31:0] ha, hwd, r;
  logic [6:0]  ri;
  wire logic   hrdy, hresp, bclk, fs, mclk, conv, pll, reg_en, shd, rec;
  wire logic [3:0]  inen, slen;
  wire logic [31:0] hrd;
  int          err_total, n_tests, cyc = 0;
  int          mdl [128];
  logic [6:0]  wq [$];
  pms_sequencer #(.INIT_CYCLES(IC), .WAKE_CYCLES(WC), .RAMP_CYCLES(RC)) i_pms_sequencer (
    .i_ref_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(ha), .i_htrans(htr),
    .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwd), .i_hready(hrdy), .o_hreadyout(hrdy),
    .o_hresp(hresp), .o_hrdata(hrd), .i_bit_clk(bclk), .i_frame_sync(fs),
    .o_mic_bitstream_clock_out(mclk), .o_in_ch_en(inen), .o_slot_en(slen),
    .o_conv_pwr(conv), .o_pll_pwr(pll), .o_regulator_en(reg_en), .o_shutdown(shd),
    .o_recording(rec));
  pms_link_host i_pms_link_host (.i_run(run), .o_bit_clk(bclk), .o_frame_sync(fs));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected read at %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic [11:0] g, input logic [11:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected pins at %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1; htr <= 2'h2; ha <= a; hwr <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0; htr <= 2'h0; hwd <= {24'h0, d};
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrd;
  endtask
  task automatic mreset();
    foreach (mdl[k]) mdl[k] = 0;
    mdl[2] = 8'h01;
    mdl[7'h73] = 8'hF0;
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    bus(1'b1, {23'h0, i, 2'h0}, d);
    if (i != 7'h77) mdl[i] = d;
    if (i == 7'h01 && d[0]) mreset();
  endtask
  task automatic rd(input logic [6:0] i, input logic [7:0] e);
    bus(1'b0, {23'h0, i, 2'h0}, 8'h0);
    chk_rd(r, {24'h0, e});
  endtask
  // Outputs are flops behind the registers, so let them settle
  task automatic pins(input logic [11:0] e);
    repeat (3) @(negedge clk);
    chk_pin({shd, reg_en, conv, pll, inen, slen}, e);
  endtask
  initial begin
    rst = 1'b1; hsel = 1'b0; htr = 2'h0; ha = 0; hwr = 1'b0; hwd = 0; run = 1'b0;
    err_total = 0; n_tests = 0;
    void'($urandom(32'h7313));
    mreset();
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, 32'h40, 8'h55);
    rd(7'h77, 8'h00);
    repeat (IC) @(posedge clk);
    rd(7'h77, 8'h80);
    rd(7'h10, 8'h00);
    rd(7'h02, 8'h01);
    pins(12'h800);
    $display("test init done");
    for (int k = 0; k < 6; k++) begin
      ri = 7'($urandom_range(8'h70, 8'h08));
      wr(ri, 8'($urandom));
      wq.push_back(ri);
    end
    bus(1'b1, 32'h400, 8'hAA);
    bus(1'b0, 32'h400, 8'h00);
    chk_rd(r, 32'h0);
    wr(7'h77, 8'h00);
    rd(7'h77, 8'h80);
    wr(7'h02, 8'h80);
    rd(7'h77, 8'h40);
    run <= 1'b1;
    repeat (WC) @(posedge clk);
    rd(7'h77, 8'h00);
    wr(7'h41, 8'h40);
    wr(7'h22, 8'h41);
    wr(7'h2B, 8'h12);
    wr(7'h73, 8'hF0);
    wr(7'h74, 8'hF0);
    wr(7'h75, 8'h60);
    pins(12'h7FF);
    for (int k = 0; k < 300 && rec !== 1'b1; k++) @(posedge clk);
    chk_pin({11'h0, rec}, 12'h1);
    $display("test wake done");
    wr(7'h02, 8'h81);
    rd(7'h77, 8'h40);
    pins(12'h400);
    repeat (RC) @(posedge clk);
    for (int k = 0; k < 40 && r[7] !== 1'b1; k++) bus(1'b0, 32'h1DC, 8'h0);
    chk_rd(r, 32'h80);
    run <= 1'b0;
    foreach (wq[j]) rd(wq[j], 8'(mdl[wq[j]]));
    $display("test sleep done");
    wr(7'h02, 8'h00);
    repeat (WC) @(posedge clk);
    run <= 1'b1;
    pins(12'h3FF);
    $display("test rewake done");
    wr(7'h02, 8'h81);
    repeat (RC + 8) @(posedge clk);
    rd(7'h77, 8'h80);
    run <= 1'b0;
    wr(7'h01, 8'h01);
    repeat (IC) @(posedge clk);
    rd(7'h74, 8'h00);
    rd(7'h02, 8'h01);
    chk_pin({11'h0, shd}, 12'h1);
    $display("test swreset done");
    wr(7'h74, 8'($urandom));
    repeat (RC + 16) @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    mreset();
    rd(7'h77, 8'h00);
    repeat (IC) @(posedge clk);
    rd(7'h74, 8'(mdl[7'h74]));
    pins(12'h800);
    $display("test power cycle done");
    finish_test();
  end
endmodule
`default_nettype wire
